// *** src/csb_cmp_alu.sv ***
`timescale 1ns/1ns
// ============================================================
// compare-immediate flag generator
// ============================================================
module csb_cmp_alu (
  input  wire logic [7:0] i_rd,    // working register value
  input  wire logic [7:0] i_imm,   // constant subtracted
  input  wire logic [7:0] i_flags, // flags before the compare
  output logic      [7:0] o_flags  // flags after the compare
);
  import csb_pkg::*;

  logic [REG_W-1:0] diff; // result is discarded, only flags kept

  assign diff = i_rd - i_imm;

  // ============================================================
  // flag update, other flags pass through
  // ============================================================
  always_comb begin
    o_flags         = i_flags;
    o_flags[FLAG_Z] = (diff == BYTE_ZERO);
    o_flags[FLAG_N] = diff[SIGN_BIT];
    // borrow out of bit 3
    o_flags[FLAG_H] = (~i_rd[HALF_BIT] & i_imm[HALF_BIT]) | (i_imm[HALF_BIT] & diff[HALF_BIT])
                    | (diff[HALF_BIT] & ~i_rd[HALF_BIT]);
    // signed overflow of the subtraction
    o_flags[FLAG_V] = (i_rd[SIGN_BIT] & ~i_imm[SIGN_BIT] & ~diff[SIGN_BIT])
                    | (~i_rd[SIGN_BIT] & i_imm[SIGN_BIT] & diff[SIGN_BIT]);
    // borrow out of bit 7
    o_flags[FLAG_C] = (~i_rd[SIGN_BIT] & i_imm[SIGN_BIT]) | (i_imm[SIGN_BIT] & diff[SIGN_BIT])
                    | (diff[SIGN_BIT] & ~i_rd[SIGN_BIT]);
  end

endmodule // csb_cmp_alu

// *** src/csb_compare_skip_branch_unit.sv ***
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// ============================================================
// Summary of operation
// - compare immediate sets Z N V C H, one cycle
// - register bit clear skips next instruction, one or two words
// - register bit set skips, flags untouched
// - i/o bit clear skips next instruction
// - i/o bit set skips, flags untouched
// - flag set branches to pc+k+1, 1/2 cycles
// - flag clear branches, flags untouched
// - carry branches test C set or clear
// - same-higher on C zero, lower on C one
// - signed ge branches when N xor V zero
// - signed lt branches when N xor V one
// - half-carry branches test H set or clear
// ============================================================
module csb_compare_skip_branch_unit (
  input  wire logic                         I_MCLK,
  input  wire logic                         I_RESET_N,
  input  wire logic [csb_pkg::ADDR_W-1:0]   I_AWADDR,
  input  wire logic                         I_AWVALID,
  output logic                              O_AWREADY,
  input  wire logic [csb_pkg::DATA_W-1:0]   I_WDATA,
  input  wire logic [csb_pkg::STRB_W-1:0]   I_WSTRB,
  input  wire logic                         I_WVALID,
  output logic                              O_WREADY,
  output logic [1:0]                        O_BRESP,
  output logic                              O_BVALID,
  input  wire logic                         I_BREADY,
  input  wire logic [csb_pkg::ADDR_W-1:0]   I_ARADDR,
  input  wire logic                         I_ARVALID,
  output logic                              O_ARREADY,
  output logic [csb_pkg::DATA_W-1:0]        O_RDATA,
  output logic [1:0]                        O_RRESP,
  output logic                              O_RVALID,
  input  wire logic                         I_RREADY,
  output logic [csb_pkg::PC_W-1:0]          O_PC,
  output logic [csb_pkg::REG_W-1:0]         O_FLAGS,
  output logic                              O_BUSY,
  output logic                              O_DONE
);
  import csb_pkg::*;

  // ============================================================
  // declarations
  // ============================================================
  logic               aw_held;    // write address captured
  logic [ADDR_W-1:0]  aw_addr;    // captured write address
  logic               w_held;     // write data captured
  logic [DATA_W-1:0]  w_data;     // captured write data
  logic [STRB_W-1:0]  w_strb;     // captured byte enables
  logic               bvalid;     // write answer pending
  logic [1:0]         bresp;      // write answer code
  logic               rvalid;     // read answer pending
  logic [1:0]         rresp;      // read answer code
  logic [DATA_W-1:0]  rdata;      // read answer data
  logic               wr_fire;    // write performed this cycle
  logic               wr_mapped;  // write address decodes
  logic               wr_ok;      // write allowed to take effect
  logic               launch;     // command write starts execution
  logic [DATA_W-1:0]  rd_word;    // read mux output
  logic               rd_mapped;  // read address decodes
  logic [DATA_W-1:0]  cmd_word;   // command as merged by strobes
  csb_op_t            cmd_op;     // current opcode
  logic [SEL_W-1:0]   cmd_sel;    // bit or flag number
  logic [DATA_W-1:0]  opnd;       // operand register
  logic [PC_W-1:0]    pc;         // program counter
  logic [REG_W-1:0]   flags;      // status_flags_register
  logic               taken;      // last outcome
  logic [CYC_W-1:0]   last_cyc;   // cycles of last instruction
  csb_state_e         state;      // execution state
  logic [CYC_W-1:0]   cnt;        // cycle being executed
  logic               hit;        // skip or branch condition true
  logic               is_skip;    // opcode is a skip
  logic               is_branch;  // opcode is a branch
  logic               is_cmp;     // opcode is a compare
  logic [PC_W-1:0]    next_pc;    // pc after this instruction
  logic [REG_W-1:0]   next_flags; // flags after this instruction
  logic [CYC_W-1:0]   next_need;  // cycles this instruction takes
  logic [REG_W-1:0]   cmp_flags;  // compare result flags
  logic [REG_W-1:0]   op_rd;      // working register operand
  logic [REG_W-1:0]   op_io;      // i/o location operand
  logic [K_W-1:0]     op_k;       // signed offset
  logic [PC_W-1:0]    k_ext;      // offset widened to pc

  // strobe merge, lanes without a strobe keep the old byte
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  // ============================================================
  // write channel
  // ============================================================
  // ready only while the slot is empty and no answer waits
  assign O_AWREADY = ~aw_held & ~bvalid;
  assign O_WREADY  = ~w_held & ~bvalid;
  assign wr_fire   = aw_held & w_held & ~bvalid;

  // address capture, order against data is free
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= I_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // data capture
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      w_held <= 1'b0;
      w_data <= WORD_ZERO;
      w_strb <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      w_held <= 1'b1;
      w_data <= I_WDATA;
      w_strb <= I_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // address decode for writes
  always_comb begin
    unique case (aw_addr)
      ADDR_CMD, ADDR_OPND, ADDR_PC, ADDR_FLAGS, ADDR_STAT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  assign cmd_word = merge({{(DATA_W-SEL_W-CMD_SEL_LSB){1'b0}}, cmd_sel, 3'h0, cmd_op}, w_data, w_strb);
  // busy blocks writes so operands cannot shift under a running instruction
  assign wr_ok    = wr_mapped & (state == ST_IDLE)
                  & ((aw_addr != ADDR_CMD) | (cmd_word[CMD_OP_LSB +: OP_W] <= OP_BRANCH_HALFCARRY_CLR));
  assign launch   = wr_fire & wr_ok & (aw_addr == ADDR_CMD);

  // write answer
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  assign O_BVALID = bvalid;
  assign O_BRESP  = bresp;

  // ============================================================
  // software registers
  // ============================================================
  // command and operand hold the instruction to execute
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cmd_op  <= OP_COMPARE_IMMEDIATE;
      cmd_sel <= 3'h0;
      opnd    <= WORD_ZERO;
    end else if (wr_fire && wr_ok) begin
      if (aw_addr == ADDR_CMD) begin
        cmd_op  <= cmd_word[CMD_OP_LSB +: OP_W];
        cmd_sel <= cmd_word[CMD_SEL_LSB +: SEL_W];
      end
      if (aw_addr == ADDR_OPND) begin
        opnd <= merge(opnd, w_data, w_strb);
      end
    end
  end

  // ============================================================
  // condition evaluation
  // ============================================================
  assign op_rd = opnd[OPND_RD_LSB +: REG_W];
  assign op_io = opnd[OPND_IO_LSB +: REG_W];
  assign op_k  = opnd[OPND_K_LSB +: K_W];
  assign k_ext = {{(PC_W-K_W){op_k[K_W-1]}}, op_k};

  csb_cmp_alu u_cmp_alu (
    .i_rd    (op_rd),
    .i_imm   (opnd[OPND_IMM_LSB +: REG_W]),
    .i_flags (flags),
    .o_flags (cmp_flags)
  );

  // per-opcode test, anything that is not a compare leaves flags alone
  always_comb begin
    hit       = 1'b0;
    is_skip   = 1'b0;
    is_branch = 1'b1;
    is_cmp    = 1'b0;
    unique case (cmd_op)
      OP_COMPARE_IMMEDIATE: begin
        is_cmp    = 1'b1;
        is_branch = 1'b0;
      end
      OP_SKIP_REG_BIT_CLEAR: begin
        hit       = ~op_rd[cmd_sel];
        is_skip   = 1'b1;
        is_branch = 1'b0;
      end
      OP_SKIP_REG_BIT_SET: begin
        hit       = op_rd[cmd_sel];
        is_skip   = 1'b1;
        is_branch = 1'b0;
      end
      OP_SKIP_IO_BIT_CLEAR: begin
        hit       = ~op_io[cmd_sel];
        is_skip   = 1'b1;
        is_branch = 1'b0;
      end
      OP_SKIP_IO_BIT_SET: begin
        hit       = op_io[cmd_sel];
        is_skip   = 1'b1;
        is_branch = 1'b0;
      end
      OP_BRANCH_FLAG_SET:      hit = flags[cmd_sel];
      OP_BRANCH_FLAG_CLEAR:    hit = ~flags[cmd_sel];
      OP_BRANCH_EQUAL:         hit = flags[FLAG_Z];
      OP_BRANCH_NOT_EQUAL:     hit = ~flags[FLAG_Z];
      OP_BRANCH_CARRY_SET:     hit = flags[FLAG_C];
      OP_BRANCH_CARRY_CLEAR:   hit = ~flags[FLAG_C];
      OP_BRANCH_SAME_HIGHER:   hit = ~flags[FLAG_C];
      OP_BRANCH_LOWER:         hit = flags[FLAG_C];
      OP_BRANCH_MINUS:         hit = flags[FLAG_N];
      OP_BRANCH_PLUS:          hit = ~flags[FLAG_N];
      OP_BRANCH_GE_SIGNED:     hit = ~(flags[FLAG_N] ^ flags[FLAG_V]);
      OP_BRANCH_LT_SIGNED:     hit = flags[FLAG_N] ^ flags[FLAG_V];
      OP_BRANCH_HALFCARRY_SET: hit = flags[FLAG_H];
      OP_BRANCH_HALFCARRY_CLR: hit = ~flags[FLAG_H];
      // illegal codes are refused at the write, never executed
      default: is_branch = 1'b0;
    endcase
  end

  // target, flags and cycle count of the instruction
  always_comb begin
    next_pc    = pc + PC_STEP1;
    next_need  = CYC_ONE;
    next_flags = is_cmp ? cmp_flags : flags;
    if (is_skip && hit) begin
      // a two-word victim needs one more word and one more cycle
      next_pc   = pc + (opnd[OPND_TWO_BIT] ? PC_STEP3 : PC_STEP2);
      next_need = opnd[OPND_TWO_BIT] ? CYC_THREE : CYC_TWO;
    end else if (is_branch && hit) begin
      next_pc   = pc + k_ext + PC_STEP1;
      next_need = CYC_TWO;
    end
  end

  // ============================================================
  // execution sequencer
  // ============================================================
  // run for exactly the instruction's cycle count, then commit
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_IDLE;
      cnt   <= CYC_ONE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= CYC_ONE;
          if (launch) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt == next_need) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + CYC_ONE;
          end
        end
        default: state <= ST_IDLE; // illegal one-hot code recovers
      endcase
    end
  end

  // pc and flags: software writes when idle, commit at the end
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pc       <= PC_RESET;
      flags    <= FLAGS_RESET;
      taken    <= 1'b0;
      last_cyc <= 2'h0;
      O_DONE   <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      if (state == ST_RUN && cnt == next_need) begin
        pc       <= next_pc;
        flags    <= next_flags;
        taken    <= hit;
        last_cyc <= next_need;
        O_DONE   <= 1'b1;
      end else if (wr_fire && wr_ok) begin
        if (aw_addr == ADDR_PC) begin
          pc <= PC_W'(merge({16'h0000, pc}, w_data, w_strb));
        end
        if (aw_addr == ADDR_FLAGS) begin
          flags <= REG_W'(merge({24'h00_0000, flags}, w_data, w_strb));
        end
      end
    end
  end

  assign O_PC    = pc;
  assign O_FLAGS = flags;
  assign O_BUSY  = (state == ST_RUN);

  // ============================================================
  // read channel
  // ============================================================
  assign O_ARREADY = ~rvalid; // one read in flight

  // read mux, unused bits read as zero
  always_comb begin
    rd_word   = WORD_ZERO;
    rd_mapped = 1'b1;
    unique case (I_ARADDR)
      ADDR_CMD: begin
        rd_word[CMD_OP_LSB +: OP_W]   = cmd_op;
        rd_word[CMD_SEL_LSB +: SEL_W] = cmd_sel;
      end
      ADDR_OPND:  rd_word = opnd;
      ADDR_PC:    rd_word[PC_W-1:0] = pc;
      ADDR_FLAGS: rd_word[REG_W-1:0] = flags;
      ADDR_STAT: begin
        rd_word[STAT_BUSY]                = O_BUSY;
        rd_word[STAT_TAKEN]               = taken;
        rd_word[STAT_CYC_LSB +: CYC_W]    = last_cyc;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  // read answer registered one cycle after the address
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= WORD_ZERO;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid <= 1'b1;
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata  <= rd_word;
    end else if (I_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  assign O_RVALID = rvalid;
  assign O_RRESP  = rresp;
  assign O_RDATA  = rdata;

endmodule // csb_compare_skip_branch_unit

// *** src/csb_pkg.sv ***
// ============================================================
// shared constants for the compare / skip / branch unit
// ============================================================
package csb_pkg;

  // ============================================================
  // bus geometry and answers
  // ============================================================
  localparam int         ADDR_W      = 8;          // byte address width
  localparam int         DATA_W      = 32;         // bus data width
  localparam int         STRB_W      = 4;          // byte lanes
  localparam int         BYTE_W      = 8;          // bits per lane
  localparam logic [1:0] RESP_OKAY   = 2'h0;       // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;       // refused or unmapped

  // ============================================================
  // register byte addresses
  // ============================================================
  localparam logic [ADDR_W-1:0] ADDR_CMD   = 8'h00; // opcode and bit select
  localparam logic [ADDR_W-1:0] ADDR_OPND  = 8'h04; // operand values
  localparam logic [ADDR_W-1:0] ADDR_PC    = 8'h08; // program counter
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h0C; // status_flags_register
  localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h10; // execution status

  // ============================================================
  // field layout
  // ============================================================
  localparam int OP_W         = 5;  // opcode width
  localparam int SEL_W        = 3;  // bit number width
  localparam int REG_W        = 8;  // working register width
  localparam int PC_W         = 16; // program counter width
  localparam int K_W          = 7;  // signed branch offset width
  localparam int CYC_W        = 2;  // cycle count width
  localparam int CMD_OP_LSB   = 0;  // opcode field
  localparam int CMD_SEL_LSB  = 8;  // bit / flag number field
  localparam int OPND_RD_LSB  = 0;  // register value
  localparam int OPND_IMM_LSB = 8;  // immediate constant
  localparam int OPND_IO_LSB  = 16; // i/o location value
  localparam int OPND_K_LSB   = 24; // relative offset
  localparam int OPND_TWO_BIT = 31; // next instruction is two words
  localparam int STAT_BUSY    = 0;  // instruction in progress
  localparam int STAT_TAKEN   = 1;  // last skip or branch was taken
  localparam int STAT_CYC_LSB = 4;  // cycles of last instruction

  // ============================================================
  // flag positions and alu bits
  // ============================================================
  localparam int FLAG_C   = 0;
  localparam int FLAG_Z   = 1;
  localparam int FLAG_N   = 2;
  localparam int FLAG_V   = 3;
  localparam int FLAG_H   = 5;
  localparam int HALF_BIT = 3; // nibble carry source
  localparam int SIGN_BIT = 7; // operand sign

  // ============================================================
  // reset values and steps
  // ============================================================
  localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;
  localparam logic [REG_W-1:0]  FLAGS_RESET = 8'h00;
  localparam logic [REG_W-1:0]  BYTE_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [PC_W-1:0]   PC_STEP1    = 16'h0001;
  localparam logic [PC_W-1:0]   PC_STEP2    = 16'h0002;
  localparam logic [PC_W-1:0]   PC_STEP3    = 16'h0003;
  localparam logic [CYC_W-1:0]  CYC_ONE     = 2'h1;
  localparam logic [CYC_W-1:0]  CYC_TWO     = 2'h2;
  localparam logic [CYC_W-1:0]  CYC_THREE   = 2'h3;

  // ============================================================
  // opcodes
  // ============================================================
  typedef logic [OP_W-1:0] csb_op_t;
  localparam csb_op_t OP_COMPARE_IMMEDIATE    = 5'h00;
  localparam csb_op_t OP_SKIP_REG_BIT_CLEAR   = 5'h01;
  localparam csb_op_t OP_SKIP_REG_BIT_SET     = 5'h02;
  localparam csb_op_t OP_SKIP_IO_BIT_CLEAR    = 5'h03;
  localparam csb_op_t OP_SKIP_IO_BIT_SET      = 5'h04;
  localparam csb_op_t OP_BRANCH_FLAG_SET      = 5'h05;
  localparam csb_op_t OP_BRANCH_FLAG_CLEAR    = 5'h06;
  localparam csb_op_t OP_BRANCH_EQUAL         = 5'h07;
  localparam csb_op_t OP_BRANCH_NOT_EQUAL     = 5'h08;
  localparam csb_op_t OP_BRANCH_CARRY_SET     = 5'h09;
  localparam csb_op_t OP_BRANCH_CARRY_CLEAR   = 5'h0A;
  localparam csb_op_t OP_BRANCH_SAME_HIGHER   = 5'h0B;
  localparam csb_op_t OP_BRANCH_LOWER         = 5'h0C;
  localparam csb_op_t OP_BRANCH_MINUS         = 5'h0D;
  localparam csb_op_t OP_BRANCH_PLUS          = 5'h0E;
  localparam csb_op_t OP_BRANCH_GE_SIGNED     = 5'h0F;
  localparam csb_op_t OP_BRANCH_LT_SIGNED     = 5'h10;
  localparam csb_op_t OP_BRANCH_HALFCARRY_SET = 5'h11;
  localparam csb_op_t OP_BRANCH_HALFCARRY_CLR = 5'h12;

  // ============================================================
  // execution states
  // ============================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1, // waiting for a command
    ST_RUN  = 2'h2  // counting instruction cycles
  } csb_state_e;

endpackage

// *** test/csb_compare_skip_branch_unit_chk.sv ***
`timescale 1ns/1ns
// ============================================================
// port checker for the compare / skip / branch unit
// ============================================================
module csb_chk (
  input wire logic        I_MCLK,
  input wire logic        I_RESET_N,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic [15:0] O_PC,
  input wire logic [7:0]  O_FLAGS,
  input wire logic        O_BUSY,
  input wire logic        O_DONE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  // done is a single pulse, never beside busy
  done_pulse_a: assert property (O_DONE |=> !O_DONE) else $error("done longer than one cycle");
  done_idle_a: assert property (O_DONE |-> !O_BUSY) else $error("done while busy");
  busy_end_a: assert property ($fell(O_BUSY) |-> O_DONE) else $error("busy ended without done");
  // no instruction lasts beyond three cycles
  busy_len_a: assert property ($rose(O_BUSY) |-> ##[1:3] !O_BUSY) else $error("busy too long");
  // state frozen until commit
  flags_hold_a: assert property (O_BUSY |-> $stable(O_FLAGS)) else $error("flags moved while busy");
  pc_hold_a: assert property (O_BUSY |-> $stable(O_PC)) else $error("pc moved while busy");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write answer dropped");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read answer dropped");
  aw_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY) else $error("write taken early");
  ar_block_a: assert property (O_RVALID |-> !O_ARREADY) else $error("read taken early");
endmodule // csb_chk
bind csb_compare_skip_branch_unit csb_chk u_chk (.*);

// *** test/csb_compare_skip_branch_unit_test.sv ***
`timescale 1ns/1ns
// ============================================================
// register-level bench
// ============================================================
module csb_compare_skip_branch_unit_test;
  import csb_pkg::*;
  logic I_MCLK, I_RESET_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [7:0] I_AWADDR, I_ARADDR, O_FLAGS;
  logic [31:0] I_WDATA, O_RDATA, v;
  logic [3:0] I_WSTRB;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_BUSY, O_DONE;
  logic [1:0] O_BRESP, O_RRESP, r;
  logic [15:0] O_PC;
  int n_fail, check_count, cyc;
  csb_compare_skip_branch_unit dut (.*);
  initial begin
    I_MCLK = 0;
    forever #5 I_MCLK = ~I_MCLK;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // handshakes judged at the falling edge, acted on after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ad, dd, got;
    ad = 0; dd = 0; got = 0;
    @(posedge I_MCLK);
    I_AWADDR <= a; I_WDATA <= d; I_AWVALID <= 1; I_WVALID <= 1; I_BREADY <= 1;
    while (!got) begin
      @(negedge I_MCLK);
      if (I_AWVALID && O_AWREADY) ad = 1;
      if (I_WVALID && O_WREADY) dd = 1;
      got = O_BVALID;
      rs = O_BRESP;
      @(posedge I_MCLK);
      if (ad) I_AWVALID <= 0;
      if (dd) I_WVALID <= 0;
    end
    I_BREADY <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ak, got;
    ak = 0; got = 0;
    @(posedge I_MCLK);
    I_ARADDR <= a; I_ARVALID <= 1; I_RREADY <= 1;
    while (!got) begin
      @(negedge I_MCLK);
      if (I_ARVALID && O_ARREADY) ak = 1;
      got = O_RVALID;
      d = O_RDATA;
      rs = O_RRESP;
      @(posedge I_MCLK);
      if (ak) I_ARVALID <= 0;
    end
    I_RREADY <= 0;
  endtask
  // one instruction from pc 0x0100, expectations worked out here
  task automatic run(input logic [4:0] op, input logic [2:0] s, input logic [7:0] f, input logic [31:0] o);
    logic [7:0] ef, res;
    logic [15:0] ep;
    logic c;
    logic [1:0] cy;
    ef = f; c = 0; res = o[7:0] - o[15:8];
    case (op)
      5'h00: begin
        ef[0] = o[7:0] < o[15:8]; ef[1] = res == 0; ef[2] = res[7];
        ef[3] = (o[7] ^ o[15]) & (o[7] ^ res[7]);
        ef[5] = o[3:0] < o[11:8];
      end
      5'h01: c = !o[s];
      5'h02: c = o[s];
      5'h03: c = !o[16 + s];
      5'h04: c = o[16 + s];
      5'h05: c = f[s];
      5'h06: c = !f[s];
      5'h07: c = f[1];
      5'h08: c = !f[1];
      5'h09, 5'h0C: c = f[0];
      5'h0A, 5'h0B: c = !f[0];
      5'h0D: c = f[2];
      5'h0E: c = !f[2];
      5'h0F: c = !(f[2] ^ f[3]);
      5'h10: c = f[2] ^ f[3];
      5'h11: c = f[5];
      default: c = !f[5];
    endcase
    cy = !c ? 2'h1 : (op < 5 && o[31]) ? 2'h3 : 2'h2;
    ep = !c ? 16'h0101 : op < 5 ? 16'h0100 + cy : 16'h0101 + {{9{o[30]}}, o[30:24]};
    wr(ADDR_PC, 32'h0000_0100, r);
    wr(ADDR_FLAGS, {24'h0, f}, r);
    wr(ADDR_OPND, o, r);
    wr(ADDR_CMD, {21'h0, s, 3'h0, op}, r);
    chk(32'(r), 32'(RESP_OKAY));
    do @(negedge I_MCLK); while (O_BUSY);
    chk(32'(O_DONE), 32'h1);
    chk(32'(O_PC), 32'(ep));
    chk(32'(O_FLAGS), 32'(ef));
    @(posedge I_MCLK);
    rd(ADDR_STAT, v, r);
    chk(32'(v[5:4]), 32'(cy));
    chk(32'(v[1]), 32'(c));
  endtask
  initial begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 0;
    I_AWADDR = 0; I_ARADDR = 0; I_WDATA = 0; I_WSTRB = 4'hF;
    n_fail = 0; check_count = 0; cyc = 0; I_RESET_N = 0;
    repeat (20) @(posedge I_MCLK);
    I_RESET_N <= 1;
    @(negedge I_MCLK);
    chk(32'(O_PC), 32'h0000_0000);
    rd(ADDR_FLAGS, v, r);
    chk(v, 32'h0000_0000);
    // every opcode against three flag patterns
    for (int op = 0; op < 19; op++) begin
      for (int p = 0; p < 3; p++) begin
        run(5'(op), 3'(op + p), p == 0 ? 8'h00 : p == 1 ? 8'h2F : 8'h04,
            {p[0], 7'h7E, 8'h3C, 8'(8'h5A + p * 8'h50), 8'hA5});
      end
    end
    // i/o bit clear taken over a two-word instruction
    run(5'h03, 3'h1, 8'h00, 32'h8000_0000);
    wr(ADDR_CMD, 32'h0000_0013, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h14, 32'h0000_0001, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(8'h14, v, r);
    chk({v[29:0], r}, {30'h0, RESP_SLVERR});
    report_and_stop();
  end
endmodule // csb_compare_skip_branch_unit_test
